// ---- verilog/external_oscillator_control.sv ----
// Control register and mode decode of the external oscillator drive.
// Assumes a byte-wide special-function register port from the core and
// an amplitude detector on the analog side; its status is asynchronous.
`include "ext_osc_defines.svh"

// What this block does
// - Bit 7 read-only crystal valid flag
// - Modes 00x off, 010 CMOS, 011 CMOS/2
// - Bit 3 reads zero, writes ignored
// - Bits 2:0 select drive band
module external_oscillator_control
    import ext_osc_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_write_in,
    input wire logic sfr_read_in,
    input wire logic amp_stable_in,
    output logic [7:0] sfr_rdata_out,
    output logic osc_enable_out,
    output logic cmos_mode_out,
    output logic rc_mode_out,
    output logic cap_mode_out,
    output logic crystal_mode_out,
    output logic div2_out,
    output logic [2:0] ext_osc_drive_select_out
);

    logic [2:0] ext_osc_mode_select_ff;
    logic [2:0] ext_osc_drive_select_ff;
    logic stable_meta_ff;
    logic stable_sync_ff;
    logic crystal_valid_flag;
    logic [7:0] reg_view;
    logic [7:0] sfr_rdata_ff;
    logic sel;
    ext_osc_mode_t mode;
    logic nxt_osc_enable;
    logic nxt_cmos;
    logic nxt_rc;
    logic nxt_cap;
    logic nxt_xtal;
    logic nxt_div2;
    logic osc_enable_ff;
    logic cmos_ff;
    logic rc_ff;
    logic cap_ff;
    logic xtal_ff;
    logic div2_ff;

    // Only the one register address answers
    assign sel = (sfr_addr_in == `EXT_OSC_CTRL_ADDR);
    assign mode = ext_osc_mode_t'(ext_osc_mode_select_ff);

    // Mode field, written by software
    // Bits 7 and 3 of a write are dropped
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ext_osc_mode_select_ff <= `EXT_OSC_MODE_RESET;
        end else if (sel && sfr_write_in) begin
            ext_osc_mode_select_ff <=
                sfr_wdata_in[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO];
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ext_osc_drive_select_ff <= `EXT_OSC_DRIVE_RESET;
        end else if (sel && sfr_write_in) begin
            ext_osc_drive_select_ff <=
                sfr_wdata_in[`EXT_OSC_DRIVE_HI:`EXT_OSC_DRIVE_LO];
        end
    end

    // Detector status crosses in from the analog side
    // Only the second flop is read by logic
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stable_meta_ff <= 1'b0;
            stable_sync_ff <= 1'b0;
        end else begin
            stable_meta_ff <= amp_stable_in;
            stable_sync_ff <= stable_meta_ff;
        end
    end

    assign crystal_valid_flag = stable_sync_ff &&
        (ext_osc_mode_select_ff[2:1] == 2'b11);

    always_comb begin
        reg_view = 8'h00;
        reg_view[`EXT_OSC_VALID_BIT] = crystal_valid_flag;
        reg_view[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO] = ext_osc_mode_select_ff;
        reg_view[`EXT_OSC_UNUSED_BIT] = 1'b0;
        reg_view[`EXT_OSC_DRIVE_HI:`EXT_OSC_DRIVE_LO] =
            ext_osc_drive_select_ff;
    end

    // Read data idles at zero between reads
    // Same-edge write and read returns the old byte
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sfr_rdata_ff <= 8'h00;
        end else if (sel && sfr_read_in) begin
            sfr_rdata_ff <= reg_view;
        end else begin
            sfr_rdata_ff <= 8'h00;
        end
    end

    always_comb begin
        nxt_osc_enable = 1'b1;
        nxt_cmos = 1'b0;
        nxt_rc = 1'b0;
        nxt_cap = 1'b0;
        nxt_xtal = 1'b0;
        nxt_div2 = 1'b0;
        case (mode)
            MODE_OFF0, MODE_OFF1: begin
                nxt_osc_enable = 1'b0;
            end
            MODE_CMOS: begin
                nxt_cmos = 1'b1;
            end
            MODE_CMOS_DIV2: begin
                nxt_cmos = 1'b1;
                nxt_div2 = 1'b1;
            end
            MODE_RC: begin
                nxt_rc = 1'b1;
            end
            MODE_CAP: begin
                nxt_cap = 1'b1;
            end
            MODE_XTAL: begin
                nxt_xtal = 1'b1;
            end
            MODE_XTAL_DIV2: begin
                nxt_xtal = 1'b1;
                nxt_div2 = 1'b1;
            end
            default: begin
                nxt_osc_enable = 1'b0;
            end
        endcase
    end

    // Enable, low for codes 00x
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            osc_enable_ff <= 1'b0;
        end else begin
            osc_enable_ff <= nxt_osc_enable;
        end
    end

    // CMOS clock input kind
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmos_ff <= 1'b0;
        end else begin
            cmos_ff <= nxt_cmos;
        end
    end

    // RC network kind
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rc_ff <= 1'b0;
        end else begin
            rc_ff <= nxt_rc;
        end
    end

    // Capacitor kind
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cap_ff <= 1'b0;
        end else begin
            cap_ff <= nxt_cap;
        end
    end

    // Crystal kind, starts the amplitude detector
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            xtal_ff <= 1'b0;
        end else begin
            xtal_ff <= nxt_xtal;
        end
    end

    // Divide-by-2 stage after the source
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div2_ff <= 1'b0;
        end else begin
            div2_ff <= nxt_div2;
        end
    end

    assign sfr_rdata_out = sfr_rdata_ff;
    assign osc_enable_out = osc_enable_ff;
    assign cmos_mode_out = cmos_ff;
    assign rc_mode_out = rc_ff;
    assign cap_mode_out = cap_ff;
    assign crystal_mode_out = xtal_ff;
    assign div2_out = div2_ff;
    assign ext_osc_drive_select_out = ext_osc_drive_select_ff;

endmodule : external_oscillator_control

// ---- verilog/ext_osc_defines.svh ----
// Offsets, field positions and reset values of the oscillator control.
// Assumes inclusion by the control module only; the package does not include it.
`ifndef EXT_OSC_DEFINES_SVH
`define EXT_OSC_DEFINES_SVH

`define EXT_OSC_CTRL_ADDR 8'hb1
`define EXT_OSC_CTRL_RESET 8'h00
`define EXT_OSC_VALID_BIT 7
`define EXT_OSC_MODE_HI 6
`define EXT_OSC_MODE_LO 4
`define EXT_OSC_UNUSED_BIT 3
`define EXT_OSC_DRIVE_HI 2
`define EXT_OSC_DRIVE_LO 0
`define EXT_OSC_MODE_RESET 3'h0
`define EXT_OSC_DRIVE_RESET 3'h0

`endif

// ---- verilog/ext_osc_pkg.sv ----
// Types shared by the external oscillator control.
// Assumes the defines header sits beside it.
package ext_osc_pkg;

    typedef enum logic [2:0] {
        MODE_OFF0 = 3'b000,
        MODE_OFF1 = 3'b001,
        MODE_CMOS = 3'b010,
        MODE_CMOS_DIV2 = 3'b011,
        MODE_RC = 3'b100,
        MODE_CAP = 3'b101,
        MODE_XTAL = 3'b110,
        MODE_XTAL_DIV2 = 3'b111
    } ext_osc_mode_t;

endpackage : ext_osc_pkg

// ---- verification/xtal_model.sv ----
// Behavioural crystal with amplitude detector.
// Assumes the crystal mode output of the block enables it.
module xtal_model #(parameter int SETTLE = 40) (
    input wire logic clk_in,
    input wire logic crystal_mode_in,
    output logic amp_stable_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    always @(posedge clk_in) begin
        if (!crystal_mode_in) cnt <= 0;
        else if (cnt < SETTLE) cnt <= cnt + 1;
    end
    assign amp_stable_out = cnt == SETTLE;
endmodule : xtal_model

// ---- verification/ext_osc_checker.sv ----
// Port assertions of the oscillator control.
// Assumes binding to the control block.
module ext_osc_checker (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic sfr_write_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic osc_enable_out,
    input wire logic cmos_mode_out,
    input wire logic rc_mode_out,
    input wire logic cap_mode_out,
    input wire logic crystal_mode_out,
    input wire logic div2_out,
    input wire logic [2:0] ext_osc_drive_select_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr;
    assign wr = sfr_write_in && sfr_addr_in == 8'hb1;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (srst_in);
    property p_flag;
        sfr_rdata_out[7] |-> crystal_mode_out || $past(crystal_mode_out);
    endproperty
    a_flag: assert property (p_flag)
        else $error("flag outside crystal");
    property p_lo;
        wr |-> ##2 osc_enable_out == ($past(sfr_wdata_in[6:5], 2) != 0)
            && cmos_mode_out == ($past(sfr_wdata_in[6:5], 2) == 2'b01)
            && div2_out == $past(sfr_wdata_in[5] & sfr_wdata_in[4], 2);
    endproperty
    a_lo: assert property (p_lo)
        else $error("off or cmos decode");
    property p_hi;
        wr |-> ##2 rc_mode_out == ($past(sfr_wdata_in[6:4], 2) == 3'h4)
            && cap_mode_out == ($past(sfr_wdata_in[6:4], 2) == 3'h5)
            && crystal_mode_out == ($past(sfr_wdata_in[6:5], 2) == 2'h3);
    endproperty
    a_hi: assert property (p_hi)
        else $error("rc cap crystal decode");
    property p_zero;
        sfr_rdata_out[3] == 1'b0;
    endproperty
    a_zero: assert property (p_zero)
        else $error("bit 3 not zero");
    property p_drv;
        wr |=> ext_osc_drive_select_out == $past(sfr_wdata_in[2:0]);
    endproperty
    a_drv: assert property (p_drv)
        else $error("drive not taken");
endmodule : ext_osc_checker
bind external_oscillator_control ext_osc_checker i_ext_osc_checker (
    .clk_in, .srst_in, .sfr_addr_in, .sfr_wdata_in, .sfr_write_in,
    .sfr_rdata_out, .osc_enable_out, .cmos_mode_out, .rc_mode_out,
    .cap_mode_out, .crystal_mode_out, .div2_out, .ext_osc_drive_select_out);

// ---- verification/tb_external_oscillator_control.sv ----
// Bench for the oscillator control.
// Assumes the crystal model and the checker.
module tb_external_oscillator_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 0, srst_in = 1, wr = 0, rd = 0;
    logic [7:0] wd = 8'h00, ad = 8'hb1, cur = 8'h00;
    wire logic amp;
    wire logic [7:0] rdata;
    wire logic [5:0] md;
    wire logic [2:0] drv;
    int bad_count = 0, n_tests = 0, seed = 32'h6eace5bc;
    always #12.5 clk_in = ~clk_in;
    external_oscillator_control i_external_oscillator_control (.clk_in,
        .srst_in, .sfr_addr_in(ad), .sfr_wdata_in(wd), .sfr_write_in(wr),
        .sfr_read_in(rd), .amp_stable_in(amp), .sfr_rdata_out(rdata),
        .osc_enable_out(md[5]), .cmos_mode_out(md[4]), .rc_mode_out(md[3]),
        .cap_mode_out(md[2]), .crystal_mode_out(md[1]), .div2_out(md[0]),
        .ext_osc_drive_select_out(drv));
    xtal_model i_xtal_model (.clk_in, .crystal_mode_in(md[1]),
        .amp_stable_out(amp));
    task automatic check(input string nm, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    function automatic logic [7:0] dec(input logic [2:0] m);
        return {2'b00, m[2:1] != 0, m[2:1] == 1, m == 4, m == 5,
            m[2:1] == 3, m[1] & m[0]};
    endfunction : dec
    // Flag x: not checked while in a crystal mode
    task automatic acc(input logic [7:0] d, input logic f,
        input logic [7:0] a = 8'hb1);
        logic [7:0] m, e;
        if (a == 8'hb1) cur = d;
        m = (cur[6:5] == 2'b11 && f === 1'bx) ? 8'h7f : 8'hff;
        e = (a == 8'hb1) ? {f === 1'b1, cur[6:4], 1'b0, cur[2:0]} : 8'h00;
        @(posedge clk_in);
        ad <= a;
        wd <= d;
        wr <= 1;
        @(posedge clk_in);
        wr <= 0;
        rd <= 1;
        @(posedge clk_in);
        rd <= 0;
        #1 check("rdata", rdata & m, e & m);
        @(posedge clk_in);
        #1 check("modes", {2'b00, md}, dec(cur[6:4]));
        check("drive", {5'h00, drv}, {5'h00, cur[2:0]});
    endtask : acc
    task automatic rst;
        srst_in <= 1;
        repeat (5) @(posedge clk_in);
        srst_in <= 0;
        cur = 8'h00;
        #1 check("reset", {2'b00, md}, 8'h00);
        check("reset_drv", {5'h00, drv}, 8'h00);
        check("reset_rd", rdata, 8'h00);
    endtask : rst
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    initial begin
        rst;
        // bit 3 and flag writes dropped
        acc(8'hcf, 0);
        // Other address: write dropped, read zero
        acc(8'h35, 0, 8'hb0);
        for (int i = 0; i < 8; i++) acc(8'(i * 17), 0);
        for (int i = 0; i < 40; i++) acc(8'($random(seed)), 1'bx);
        // Mid-run reset also stops the crystal model
        @(posedge clk_in);
        rst;
        // crystal start, drive 001, not yet valid
        acc(8'h61, 0);
        repeat (40000) @(posedge clk_in);
        acc(8'h61, 1);
        acc(8'h60, 1);
        // flag drops once mode leaves crystal
        acc(8'h21, 0);
        test_done;
    end
    initial begin
        #2ms;
        bad_count++;
        test_done;
    end
endmodule : tb_external_oscillator_control
